/* rtl/cdm_ctrl.v */
// Chosen here: register access over Wishbone and the address map.
`timescale 1ns/1ps
// What this block does
// - front dark plus rear glare darkens mirror
// - reverse gear keeps mirror clear
// - both sensors lit means no darkening
// - heading quantised to eight shown directions
// - boundaries at 22.5 plus multiples of 45
// - hysteresis around every direction boundary
// - displayed heading refreshed every two seconds
// - short press toggles compass display
// - display state survives ignition cycles
// - 6 to 9 s hold enters zone mode
// - hold in zone mode steps zone, wraps
// - release in zone mode stores zone
// - heading returns five seconds after zone set
// - hold over 9 s clears calibration
// - uncalibrated shows C until circling completes
// - two low speed circles complete calibration
// - 3 to 6 s hold toggles dimming, LED
// - dimming enabled at every vehicle start
`include "cdm_regs.vh"

module cdm_ctrl #(
  parameter TICK_CYC = `CDM_CLK_HZ / 1000000 * `CDM_TICK_US
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [3:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Vehicle pins
  input wire front_dark_i,
  input wire rear_glare_i,
  input wire reverse_i,
  input wire ignition_i,
  input wire button_i,
  input wire low_speed_i,
  // Magnetometer heading, degrees 0 to 359
  input wire [8:0] heading_i,
  // Mirror and display
  output reg dimming_mirror_dark_o,
  output reg dim_led_o,
  output reg [1:0] disp_mode_o,
  output reg [3:0] disp_val_o
);

  localparam ST_RUN = 1'b0;
  localparam ST_ZONE = 1'b1;

  // ==========================================================
  // Pin synchronisers
  wire [`CDM_NPIN-1:0] pins = {low_speed_i, button_i, ignition_i,
                               reverse_i, rear_glare_i, front_dark_i};
  reg [`CDM_NPIN-1:0] s1_reg;
  reg [`CDM_NPIN-1:0] s2_reg;
  reg [`CDM_NPIN-1:0] s3_reg;
  reg [`CDM_NPIN-1:0] pin_reg;
  genvar gi;
  generate
    for (gi = 0; gi < `CDM_NPIN; gi = gi + 1) begin : g_sync
      always @(posedge clk_i) begin
        if (rst_i) begin
          s1_reg[gi] <= 1'b0;
          s2_reg[gi] <= 1'b0;
          s3_reg[gi] <= 1'b0;
          pin_reg[gi] <= 1'b0;
        end else begin
          s1_reg[gi] <= pins[gi];
          s2_reg[gi] <= s1_reg[gi];
          s3_reg[gi] <= s2_reg[gi];
          // Change accepted only once two stages agree
          if (s2_reg[gi] == s3_reg[gi]) begin
            pin_reg[gi] <= s3_reg[gi];
          end
        end
      end
    end
  endgenerate

  wire ign = pin_reg[`CDM_P_IGN];
  wire btn = pin_reg[`CDM_P_BTN];

  // ==========================================================
  // Millisecond tick
  reg [15:0] tick_cnt_reg;
  wire tick = (tick_cnt_reg == TICK_CYC[15:0] - 16'h0001);
  always @(posedge clk_i) begin
    if (rst_i || tick) begin
      tick_cnt_reg <= 16'h0000;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 16'h0001;
    end
  end

  // ==========================================================
  // Heading quantiser
  function [2:0] quant;
    input [8:0] h;
    reg [9:0] q;
    begin
      q = ({h, 1'b0} + `CDM_HALF_SECT2) / `CDM_SECT2;
      quant = q[2:0];
    end
  endfunction

  wire [2:0] raw_sec = quant(heading_i);
  reg [2:0] sec_reg;
  reg [2:0] raw_prev_reg;
  wire [9:0] ctr2 = sec_reg * `CDM_SECT2;
  wire signed [11:0] d_raw = $signed({2'b00, heading_i, 1'b0}) -
                             $signed({2'b00, ctr2});
  wire signed [11:0] d_wrap = (d_raw > `CDM_HALF_TURN2) ?
                              d_raw - `CDM_FULL_TURN2 :
                              (d_raw < -`CDM_HALF_TURN2) ?
                              d_raw + `CDM_FULL_TURN2 : d_raw;
  wire signed [11:0] thr = $signed({2'b00, `CDM_HALF_SECT2}) +
                           (`CDM_HYST_DEG <<< 1);
  always @(posedge clk_i) begin
    if (rst_i) begin
      sec_reg <= 3'h0;
    end else if (d_wrap > thr || d_wrap < -thr) begin
      // Must clear the boundary by the margin before moving
      sec_reg <= raw_sec;
    end
  end

  // ==========================================================
  // Calibration by circling
  reg cal_reg;
  reg signed [5:0] rot_reg;
  reg cal_clr;
  wire step_up = (raw_sec == raw_prev_reg + 3'h1);
  wire step_dn = (raw_sec == raw_prev_reg - 3'h1);
  wire slow = pin_reg[`CDM_P_SLOW];
  wire cal_hit = (rot_reg >= `CDM_CAL_STEPS) ||
                 (rot_reg <= -`CDM_CAL_STEPS);
  always @(posedge clk_i) begin
    if (rst_i) begin
      cal_reg <= 1'b0;
      rot_reg <= 6'sh00;
      raw_prev_reg <= 3'h0;
    end else begin
      raw_prev_reg <= raw_sec;
      if (cal_hit && !cal_reg) begin
        // Set beats a clear in the same cycle
        cal_reg <= 1'b1;
      end else if (cal_clr) begin
        cal_reg <= 1'b0;
      end
      if (cal_clr || cal_reg) begin
        rot_reg <= 6'sh00;
      end else if (slow && step_up) begin
        rot_reg <= rot_reg + 6'sh01;
      end else if (slow && step_dn) begin
        rot_reg <= rot_reg - 6'sh01;
      end
    end
  end

  // ==========================================================
  // Button timing and mode machine
  reg btn_prev_reg;
  reg ign_prev_reg;
  reg [13:0] hold_reg;
  reg [13:0] zt_reg;
  reg [13:0] step_reg;
  reg [13:0] ref_reg;
  reg state_reg;
  reg disp_on_reg;
  reg dim_en_reg;
  reg [3:0] zone_reg;
  reg [2:0] shown_reg;
  wire rel = btn_prev_reg && !btn;
  wire bus_wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o &&
                wb_sel_i[0];
  wire wr_ctrl = bus_wr && (wb_adr_i == `CDM_ADR_CTRL);
  wire wr_zone = bus_wr && (wb_adr_i == `CDM_ADR_ZONE) &&
                 (wb_dat_i[3:0] != 4'h0);
  wire is_short = hold_reg < `CDM_T_SHORT_MS;
  wire is_dim = hold_reg > `CDM_T_SHORT_MS && hold_reg < `CDM_T_DIM_MS;
  wire is_zone = hold_reg > `CDM_T_DIM_MS && hold_reg < `CDM_T_ZONE_MS;
  wire is_clr = hold_reg > `CDM_T_ZONE_MS;

  always @* begin
    cal_clr = (wr_ctrl && wb_dat_i[`CDM_CTRL_CLR]) ||
              (rel && state_reg == ST_RUN && is_clr);
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      btn_prev_reg <= 1'b0;
      ign_prev_reg <= 1'b0;
      hold_reg <= 14'h0000;
      zt_reg <= 14'h0000;
      step_reg <= 14'h0000;
      ref_reg <= 14'h0000;
      state_reg <= ST_RUN;
      disp_on_reg <= 1'b1;
      dim_en_reg <= 1'b1;
      zone_reg <= `CDM_RST_ZONE;
      shown_reg <= 3'h0;
    end else begin
      btn_prev_reg <= btn;
      ign_prev_reg <= ign;
      // Held-duration timer, saturating
      if (!btn) begin
        hold_reg <= 14'h0000;
      end else if (tick && hold_reg != `CDM_HOLD_MAX) begin
        hold_reg <= hold_reg + 14'h0001;
      end
      // Two-second display refresh
      if (tick) begin
        if (ref_reg == `CDM_T_REFRESH_MS - 14'h0001) begin
          ref_reg <= 14'h0000;
          shown_reg <= sec_reg;
        end else begin
          ref_reg <= ref_reg + 14'h0001;
        end
      end
      case (state_reg)
        ST_RUN: begin
          if (rel) begin
            if (is_short) begin
              disp_on_reg <= !disp_on_reg;
            end else if (is_dim) begin
              dim_en_reg <= !dim_en_reg;
            end else if (is_zone) begin
              state_reg <= ST_ZONE;
              zt_reg <= 14'h0000;
            end
          end
        end
        ST_ZONE: begin
          if (btn) begin
            zt_reg <= 14'h0000;
            if (tick) begin
              if (step_reg == `CDM_T_STEP_MS - 14'h0001) begin
                step_reg <= 14'h0000;
                // Stepping runs during the hold, not on release
                if (zone_reg == `CDM_ZONE_MAX) begin
                  zone_reg <= `CDM_ZONE_MIN;
                end else begin
                  zone_reg <= zone_reg + 4'h1;
                end
              end else begin
                step_reg <= step_reg + 14'h0001;
              end
            end
          end else begin
            // Zone shown at release is already the stored zone
            step_reg <= 14'h0000;
            if (tick) begin
              if (zt_reg == `CDM_T_RETURN_MS - 14'h0001) begin
                state_reg <= ST_RUN;
              end else begin
                zt_reg <= zt_reg + 14'h0001;
              end
            end
          end
        end
        default: begin
          state_reg <= ST_RUN;
        end
      endcase
      if (wr_ctrl) begin
        disp_on_reg <= wb_dat_i[`CDM_CTRL_DISP];
        dim_en_reg <= wb_dat_i[`CDM_CTRL_DIM];
      end
      if (wr_zone) begin
        zone_reg <= wb_dat_i[3:0];
      end
      // Display state is never reset by ignition
      if (ign && !ign_prev_reg) begin
        dim_en_reg <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Mirror and display outputs
  wire dark = ign && dim_en_reg && !pin_reg[`CDM_P_REV] &&
              pin_reg[`CDM_P_FRONT] && pin_reg[`CDM_P_REAR];
  always @(posedge clk_i) begin
    if (rst_i) begin
      dimming_mirror_dark_o <= 1'b0;
      dim_led_o <= 1'b0;
      disp_mode_o <= `CDM_DISP_BLANK;
      disp_val_o <= 4'h0;
    end else begin
      // Front lit blocks dimming; reverse overrides all
      dimming_mirror_dark_o <= dark;
      dim_led_o <= ign && dim_en_reg;
      if (!ign) begin
        disp_mode_o <= `CDM_DISP_BLANK;
        disp_val_o <= 4'h0;
      end else if (state_reg == ST_ZONE) begin
        disp_mode_o <= `CDM_DISP_ZONE;
        disp_val_o <= zone_reg;
      end else if (!disp_on_reg) begin
        disp_mode_o <= `CDM_DISP_BLANK;
        disp_val_o <= 4'h0;
      end else if (!cal_reg) begin
        disp_mode_o <= `CDM_DISP_UNCAL;
        disp_val_o <= 4'h0;
      end else begin
        disp_mode_o <= `CDM_DISP_HEAD;
        disp_val_o <= {1'b0, shown_reg};
      end
    end
  end

  // ==========================================================
  // Wishbone slave, one wait state
  reg [31:0] rd_data;
  always @* begin
    rd_data = 32'h00000000;
    case (wb_adr_i)
      `CDM_ADR_CTRL: begin
        rd_data[`CDM_CTRL_DISP] = disp_on_reg;
        rd_data[`CDM_CTRL_DIM] = dim_en_reg;
      end
      `CDM_ADR_ZONE: begin
        rd_data[3:0] = zone_reg;
      end
      `CDM_ADR_STAT: begin
        rd_data[`CDM_ST_DARK] = dimming_mirror_dark_o;
        rd_data[`CDM_ST_CAL] = cal_reg;
        rd_data[`CDM_ST_ZONE] = state_reg;
        rd_data[`CDM_ST_IGN] = ign;
      end
      `CDM_ADR_HEAD: begin
        rd_data[2:0] = sec_reg;
      end
      default: begin
        rd_data = 32'h00000000;
      end
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      if (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i) begin
        wb_dat_o <= rd_data;
      end
    end
  end

endmodule // cdm_ctrl

/* rtl/cdm_regs.vh */
`ifndef CDM_REGS_VH
`define CDM_REGS_VH
// ==========================================================
// Register map (byte addresses)
`define CDM_ADR_CTRL 4'h0
`define CDM_ADR_ZONE 4'h4
`define CDM_ADR_STAT 4'h8
`define CDM_ADR_HEAD 4'hC
// ==========================================================
// Control fields
`define CDM_CTRL_DISP 0
`define CDM_CTRL_DIM 1
`define CDM_CTRL_CLR 2
// ==========================================================
// Status fields
`define CDM_ST_DARK 0
`define CDM_ST_CAL 1
`define CDM_ST_ZONE 2
`define CDM_ST_IGN 3
// ==========================================================
// Zone reset value and wrap limits
`define CDM_RST_ZONE 4'h1
`define CDM_ZONE_MAX 4'hF
`define CDM_ZONE_MIN 4'h1
// ==========================================================
// Timing, clock and tick
`define CDM_CLK_HZ 40000000
`define CDM_TICK_US 1000
`define CDM_T_SHORT_MS 14'd3000
`define CDM_T_DIM_MS 14'd6000
`define CDM_T_ZONE_MS 14'd9000
`define CDM_T_REFRESH_MS 14'd2000
`define CDM_T_RETURN_MS 14'd5000
`define CDM_T_STEP_MS 14'd1000
`define CDM_HOLD_MAX 14'h3FFF
// ==========================================================
// Heading geometry, degrees doubled except CDM_HYST_DEG (plain degrees) and CDM_CAL_STEPS (sector steps)
`define CDM_HALF_SECT2 10'h02D
`define CDM_SECT2 10'h05A
`define CDM_HALF_TURN2 12'sh168
`define CDM_FULL_TURN2 12'sh2D0
`define CDM_HYST_DEG 12'sh005
`define CDM_CAL_STEPS 6'sh10
// ==========================================================
// Display modes
`define CDM_DISP_BLANK 2'h0
`define CDM_DISP_HEAD 2'h1
`define CDM_DISP_ZONE 2'h2
`define CDM_DISP_UNCAL 2'h3
// Pin vector positions
`define CDM_P_FRONT 0
`define CDM_P_REAR 1
`define CDM_P_REV 2
`define CDM_P_IGN 3
`define CDM_P_BTN 4
`define CDM_P_SLOW 5
`define CDM_NPIN 6
`endif

/* verification/cdm_ctrl_properties.sv */
`timescale 1ns/1ps
// ==================================
// Port checker
module cdm_ctrl_chk (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Bus
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  // Pins
  input wire front_dark_i,
  input wire rear_glare_i,
  input wire reverse_i,
  input wire ignition_i,
  input wire button_i,
  // Outputs
  input wire dimming_mirror_dark_o,
  input wire dim_led_o,
  input wire [1:0] disp_mode_o,
  input wire [3:0] disp_val_o
);
  // Eight cycles cover the pin sync chain plus the output stage
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  AST_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus ack missing");
  AST_DARK: assert property (
    (ignition_i && front_dark_i && rear_glare_i && !reverse_i && dim_led_o)[*8]
    |-> dimming_mirror_dark_o) else $error("mirror not dark");
  AST_REV: assert property (
    reverse_i[*8] |-> !dimming_mirror_dark_o) else $error("dark in reverse");
  AST_BRIGHT: assert property (
    (!front_dark_i)[*8] |-> !dimming_mirror_dark_o) else $error("dark lit");
  AST_NOLED: assert property (
    (!ignition_i)[*8] |-> !dim_led_o && disp_mode_o == 2'h0)
    else $error("led or display with ignition off");
  AST_HEADV: assert property (
    disp_mode_o == 2'h1 |-> disp_val_o < 4'h8) else $error("bad sector");
  AST_ZONEV: assert property (
    disp_mode_o == 2'h2 |-> disp_val_o != 4'h0) else $error("bad zone");
  AST_BLANK: assert property (
    disp_mode_o == 2'h0 || disp_mode_o == 2'h3 |-> disp_val_o == 4'h0)
    else $error("value in blank or uncal mode");
  AST_HOLD: assert property (
    (button_i && ignition_i)[*8] |-> $stable(dim_led_o))
    else $error("dimming changed while held");
  COV_DARK: cover property ($rose(dimming_mirror_dark_o));
  COV_ZONE: cover property (disp_mode_o == 2'h2);
  COV_UNCAL: cover property (disp_mode_o == 2'h3);
endmodule // cdm_ctrl_chk

bind cdm_ctrl cdm_ctrl_chk CHK (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .front_dark_i(front_dark_i), .rear_glare_i(rear_glare_i),
  .reverse_i(reverse_i), .ignition_i(ignition_i), .button_i(button_i),
  .dimming_mirror_dark_o(dimming_mirror_dark_o), .dim_led_o(dim_led_o),
  .disp_mode_o(disp_mode_o), .disp_val_o(disp_val_o));

/* verification/cdm_ctrl_tb_top.sv */
`timescale 1ns/1ps
`include "cdm_regs.vh"
// ==================================
// Bench top
module cdm_ctrl_tb_top;
  localparam int TK = 2;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [3:0] sel = 4'hF;
  logic [31:0] wdat = 32'h0;
  logic fd = 1'b0;
  logic rg = 1'b0;
  logic rev = 1'b0;
  logic ign = 1'b0;
  logic [31:0] rv;
  wire btn, slow, ack, dark, led;
  wire [8:0] hd;
  wire [31:0] rdat;
  wire [1:0] mode;
  wire [3:0] val;
  int n_errors = 0;
  int n_checks = 0;
  int cnt = 0;
  int hs[5] = '{90, 114, 120, 110, 105};
  logic [31:0] ss[5] = '{32'h2, 32'h2, 32'h3, 32'h3, 32'h2};

  always #12.5 clk_i = ~clk_i;

  cdm_ctrl #(.TICK_CYC(TK)) DUT (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .front_dark_i(fd), .rear_glare_i(rg), .reverse_i(rev),
    .ignition_i(ign), .button_i(btn), .low_speed_i(slow),
    .heading_i(hd), .dimming_mirror_dark_o(dark), .dim_led_o(led),
    .disp_mode_o(mode), .disp_val_o(val));
  cdm_pins #(.TK(TK)) PTN (.clk_i(clk_i), .button_o(btn),
    .low_speed_o(slow), .heading_o(hd));

  task automatic stop_test;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s exp %0h got %0h", nm, e, g);
    end
  endtask
  // Request held until ack is seen high at a rising edge
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    rv = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rc(input string nm, input logic [3:0] a,
                    input logic [31:0] e);
    bus(1'b0, a, 32'h0, 4'hF);
    chk(nm, e, rv);
  endtask
  // Output picked by k: 0 dark, 1 led, 2 mode, 3 value
  task automatic ko(input string nm, input logic [31:0] e, input int k);
    @(negedge clk_i);
    chk(nm, e, k == 0 ? dark : k == 1 ? led : k == 2 ? mode : val);
    @(posedge clk_i);
  endtask
  task automatic cy(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  always @(posedge clk_i) begin
    cnt <= cnt + 1;
    if (cnt == 95000) begin
      n_errors++;
      stop_test();
    end
  end

  initial begin
    cy(16);
    rst_i <= 1'b0;
    rc("ctrl", `CDM_ADR_CTRL, 32'h3);
    rc("zone", `CDM_ADR_ZONE, 32'h1);
    rc("stat", `CDM_ADR_STAT, 32'h0);
    rc("gap", 4'h1, 32'h0);
    ign <= 1'b1;
    fd <= 1'b1;
    rg <= 1'b1;
    cy(16);
    ko("dark", 32'h1, 0);
    rev <= 1'b1;
    cy(8);
    ko("dark", 32'h0, 0);
    rev <= 1'b0;
    cy(8);
    ko("dark", 32'h1, 0);
    fd <= 1'b0;
    cy(8);
    ko("dark", 32'h0, 0);
    PTN.spin(3, 1'b0);
    rc("stat", `CDM_ADR_STAT, 32'hA);
    cy(4200);
    ko("mode", 32'h1, 2);
    for (int i = 0; i < 5; i++) begin
      PTN.heading_o <= 9'(hs[i]);
      cy(4);
      rc("sect", `CDM_ADR_HEAD, ss[i]);
    end
    cy(4200);
    ko("shown", 32'h2, 3);
    PTN.press(100);
    cy(12);
    ko("mode", 32'h0, 2);
    PTN.press(4000);
    cy(12);
    ko("led", 32'h0, 1);
    ign <= 1'b0;
    cy(12);
    ign <= 1'b1;
    cy(12);
    ko("led", 32'h1, 1);
    rc("ctrl", `CDM_ADR_CTRL, 32'h2);
    PTN.press(100);
    cy(12);
    ko("mode", 32'h1, 2);
    bus(1'b1, `CDM_ADR_ZONE, 32'h0, 4'hF);
    rc("zone", `CDM_ADR_ZONE, 32'h1);
    bus(1'b1, `CDM_ADR_ZONE, 32'hE, 4'hF);
    PTN.press(7000);
    cy(12);
    ko("mode", 32'h2, 2);
    ko("val", 32'hE, 3);
    PTN.press(2500);
    cy(12);
    ko("val", 32'h1, 3);
    rc("zone", `CDM_ADR_ZONE, 32'h1);
    cy(5100 * TK);
    ko("mode", 32'h1, 2);
    PTN.press(9500);
    cy(12);
    ko("mode", 32'h3, 2);
    PTN.spin(2, 1'b1);
    ko("mode", 32'h1, 2);
    bus(1'b1, `CDM_ADR_CTRL, 32'h5, 4'hF);
    rc("stat", `CDM_ADR_STAT, 32'h8);
    ko("mode", 32'h3, 2);
    ko("led", 32'h0, 1);
    // Low byte lane off: write must be ignored
    bus(1'b1, `CDM_ADR_CTRL, 32'h2, 4'hE);
    rc("ctrl", `CDM_ADR_CTRL, 32'h1);
    stop_test();
  end
endmodule // cdm_ctrl_tb_top

/* verification/cdm_pins.sv */
`timescale 1ns/1ps
// ==================================
// Driver side: button, speed, magnetometer
module cdm_pins #(
  parameter int TK = 2
) (
  // Clock
  input wire clk_i,
  // Toward the mirror
  output logic button_o,
  output logic low_speed_o,
  output logic [8:0] heading_o
);
  initial begin
    button_o = 1'b0;
    low_speed_o = 1'b0;
    heading_o = 9'h000;
  end
  task automatic press(input int ms);
    @(posedge clk_i);
    button_o <= 1'b1;
    repeat (ms * TK) @(posedge clk_i);
    button_o <= 1'b0;
  endtask
  // Either turn sense; calibration must accept both
  task automatic spin(input int turns, input bit up);
    @(posedge clk_i);
    low_speed_o <= 1'b1;
    repeat (turns * 360) begin
      repeat (4) @(posedge clk_i);
      if (up)
        heading_o <= (heading_o == 9'h167) ? 9'h000 : heading_o + 9'h001;
      else
        heading_o <= (heading_o == 9'h000) ? 9'h167 : heading_o - 9'h001;
    end
    @(posedge clk_i);
    low_speed_o <= 1'b0;
  endtask
endmodule // cdm_pins
